/* logic/trc_pkg.sv */
// Constants for the transmitter configuration register bank
package trc_pkg;

  // ----------------------------------------------------------------
  // Register port widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int CAL_W = 7;
  localparam int COEF_W = 6;
  localparam int COEF_AW = 3;
  localparam int COEF_N = 7;
  localparam int RATE_W = 16;
  localparam int ACC_W = 21;
  localparam int LDO_N = 6;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [6:0] OFS_RC_COARSE = 7'h63;
  localparam logic [6:0] OFS_RC_FINE = 7'h64;
  localparam logic [6:0] OFS_REG_EN = 7'h65;
  localparam logic [6:0] OFS_REG_LVL = 7'h66;
  localparam logic [6:0] OFS_COEF_ADDR = 7'h6B;
  localparam logic [6:0] OFS_COEF_VAL = 7'h6C;
  localparam logic [6:0] OFS_TX_POWER = 7'h6D;
  localparam logic [6:0] OFS_RATE_HI = 7'h6E;
  localparam logic [6:0] OFS_RATE_LO = 7'h6F;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_OVR = 7;
  localparam int BIT_SPOR = 7;
  localparam int BIT_DIGPWDN = 0;
  localparam int BIT_ENOVR = 7;
  localparam int BIT_XTAL = 6;
  localparam int BIT_TSENS = 5;
  localparam int BIT_SLOWOSC = 4;
  localparam int BIT_ANT_SW = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_RC_COARSE = 8'h00;
  localparam logic [7:0] RST_RC_FINE = 8'h00;
  localparam logic [7:0] RST_REG_EN = 8'h81;
  localparam logic [7:0] RST_REG_LVL = 8'h00;
  localparam logic [2:0] RST_COEF_ADDR = 3'h0;
  localparam logic [3:0] RST_TX_POWER = 4'h8;
  localparam logic [7:0] RST_RATE_HI = 8'h0A;
  localparam logic [7:0] RST_RATE_LO = 8'h3D;

  // Gaussian shaping, BT 0.5
  localparam logic [5:0] COEF_RST [0:6] = '{6'h01, 6'h03, 6'h06, 6'h0A, 6'h0F, 6'h13, 6'h14};

  // ----------------------------------------------------------------
  // Rate timing: accumulator steps at 1 MHz
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int STEP_HZ = 1_000_000;
  localparam int STEP_DIV = CLK_HZ / STEP_HZ;
  localparam int BASE_CARRY = 16;
  localparam int SCALED_CARRY = 21;

endpackage : trc_pkg

/* logic/trc_coef_mem.sv */
// Shaping filter coefficient table with registered read data
`timescale 1ns/1ps

module trc_coef_mem #(
  parameter int N = trc_pkg::COEF_N,
  parameter int AW = trc_pkg::COEF_AW,
  parameter int DW = trc_pkg::COEF_W
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wr_data_i,
  output logic [DW-1:0] rd_data_o
);

  typedef struct packed {
    logic [N-1:0][DW-1:0] tab;
    logic [DW-1:0] rd;
  } trc_mem_state_t;

  trc_mem_state_t st;
  trc_mem_state_t next_st;

  // ----------------------------------------------------------------
  // Table update and read
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    if (wr_en_i && (32'(addr_i) < N))
    begin
      next_st.tab[addr_i] = wr_data_i;
    end
    if (32'(addr_i) < N)
    begin
      next_st.rd = next_st.tab[addr_i];
    end
    else
    begin
      next_st.rd = '0;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      for (int i = 0; i < N; i++)
      begin
        st.tab[i] <= trc_pkg::COEF_RST[i];
      end
      st.rd <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rd_data_o = st.rd;

endmodule : trc_coef_mem

/* logic/trc_regs.sv */
// Transmitter configuration register bank
`timescale 1ns/1ps

// Operation
// - Coarse reads show internal result unless overridden
// - Coarse override uses written coarse value
// - Fine reads show internal result unless overridden
// - Fine override uses written fine value
// - Regulator enables reset to 0x81
// - Override policy: force both ways or on-only
// - Crystal, sensor, slow oscillator enables; bit3 reserved
// - Three-bit digital regulator level setting
// - Three-bit coefficient address, reset zero
// - Coefficients reset to Gaussian BT 0.5
// - Coefficient value reads/writes selected entry
// - Switch set: high during transmit only
// - Switch clear: control always low
// - Three-bit power field, register resets 0x08
// - Rate from 16-bit value, base scale
// - Scale set: rate divides by 2^21
// - Rate resets to 40 kbps
module trc_regs (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [6:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [6:0] int_coarse_i,
  input wire logic [6:0] int_fine_i,
  input wire logic [5:0] sm_ldo_en_i,
  input wire logic tx_mode_i,
  input wire logic rate_scale_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output logic [6:0] coarse_cal_o,
  output logic [6:0] fine_cal_o,
  output logic [5:0] ldo_en_o,
  output logic smart_por_en_o,
  output logic dig_pwdn_en_o,
  output logic xtal_ovr_o,
  output logic temp_sensor_en_o,
  output logic slow_osc_enable_o,
  output logic [2:0] dig_ldo_level_o,
  output logic antenna_switch_ctrl_o,
  output logic [2:0] tx_power_o,
  output logic [15:0] tx_rate_o,
  output logic tx_bit_tick_o
);

  typedef struct packed {
    logic [7:0] coarse;
    logic [7:0] fine;
    logic [7:0] reg_en;
    logic [7:0] reg_lvl;
    logic [2:0] coef_addr;
    logic [3:0] tx_power;
    logic [7:0] rate_hi;
    logic [7:0] rate_lo;
    logic [7:0] rd_data;
    logic rd_valid;
    logic [6:0] coarse_use;
    logic [6:0] fine_use;
    logic [5:0] ldo_en;
    logic ant_sw;
    logic [3:0] div;
    logic [20:0] acc;
    logic tick;
  } trc_state_t;

  trc_state_t st;
  trc_state_t next_st;
  logic [5:0] coef_rd;
  logic coef_wr;
  logic [21:0] acc_sum;

  // ----------------------------------------------------------------
  // Coefficient table
  // ----------------------------------------------------------------
  // Selected entry write
  assign coef_wr = wr_en_i && (addr_i == trc_pkg::OFS_COEF_VAL);

  trc_coef_mem trc_coef_mem_inst (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .wr_en_i(coef_wr),
    .addr_i(st.coef_addr),
    .wr_data_i(wr_data_i[5:0]),
    .rd_data_o(coef_rd)
  );

  assign acc_sum = {1'b0, st.acc} + {6'h00, st.rate_hi, st.rate_lo};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.rd_valid = 1'b0;
    // Register writes
    if (wr_en_i)
    begin
      if (addr_i == trc_pkg::OFS_RC_COARSE)
      begin
        next_st.coarse = wr_data_i;
      end
      else if (addr_i == trc_pkg::OFS_RC_FINE)
      begin
        next_st.fine = wr_data_i;
      end
      else if (addr_i == trc_pkg::OFS_REG_EN)
      begin
        next_st.reg_en = wr_data_i;
      end
      else if (addr_i == trc_pkg::OFS_REG_LVL)
      begin
        next_st.reg_lvl = wr_data_i & 8'hF7;
      end
      else if (addr_i == trc_pkg::OFS_COEF_ADDR)
      begin
        next_st.coef_addr = wr_data_i[2:0];
      end
      else if (addr_i == trc_pkg::OFS_TX_POWER)
      begin
        next_st.tx_power = wr_data_i[3:0];
      end
      else if (addr_i == trc_pkg::OFS_RATE_HI)
      begin
        next_st.rate_hi = wr_data_i;
      end
      else if (addr_i == trc_pkg::OFS_RATE_LO)
      begin
        next_st.rate_lo = wr_data_i;
      end
    end
    // Register reads, answered next cycle
    if (rd_en_i)
    begin
      next_st.rd_valid = 1'b1;
      if (addr_i == trc_pkg::OFS_RC_COARSE)
      begin
        next_st.rd_data = {st.coarse[trc_pkg::BIT_OVR],
          st.coarse[trc_pkg::BIT_OVR] ? st.coarse[6:0] : int_coarse_i};
      end
      else if (addr_i == trc_pkg::OFS_RC_FINE)
      begin
        next_st.rd_data = {st.fine[trc_pkg::BIT_OVR],
          st.fine[trc_pkg::BIT_OVR] ? st.fine[6:0] : int_fine_i};
      end
      else if (addr_i == trc_pkg::OFS_REG_EN)
      begin
        next_st.rd_data = st.reg_en;
      end
      else if (addr_i == trc_pkg::OFS_REG_LVL)
      begin
        next_st.rd_data = st.reg_lvl;
      end
      else if (addr_i == trc_pkg::OFS_COEF_ADDR)
      begin
        next_st.rd_data = {5'h00, st.coef_addr};
      end
      else if (addr_i == trc_pkg::OFS_COEF_VAL)
      begin
        next_st.rd_data = {2'h0, coef_rd};
      end
      else if (addr_i == trc_pkg::OFS_TX_POWER)
      begin
        next_st.rd_data = {4'h0, st.tx_power};
      end
      else if (addr_i == trc_pkg::OFS_RATE_HI)
      begin
        next_st.rd_data = st.rate_hi;
      end
      else if (addr_i == trc_pkg::OFS_RATE_LO)
      begin
        next_st.rd_data = st.rate_lo;
      end
      else
      begin
        next_st.rd_data = 8'h00;
      end
    end
    next_st.coarse_use = st.coarse[trc_pkg::BIT_OVR] ? st.coarse[6:0] : int_coarse_i;
    next_st.fine_use = st.fine[trc_pkg::BIT_OVR] ? st.fine[6:0] : int_fine_i;
    if (st.reg_lvl[trc_pkg::BIT_ENOVR])
    begin
      next_st.ldo_en = st.reg_en[6:1];
    end
    else
    begin
      next_st.ldo_en = st.reg_en[6:1] | sm_ldo_en_i;
    end
    next_st.ant_sw = st.tx_power[trc_pkg::BIT_ANT_SW] & tx_mode_i;
    next_st.tick = 1'b0;
    if (st.div == 4'(trc_pkg::STEP_DIV - 1))
    begin
      next_st.div = 4'h0;
      if (rate_scale_i)
      begin
        next_st.tick = acc_sum[trc_pkg::SCALED_CARRY];
        next_st.acc = acc_sum[20:0];
      end
      else
      begin
        next_st.tick = acc_sum[trc_pkg::BASE_CARRY];
        next_st.acc = {5'h00, acc_sum[15:0]};
      end
    end
    else
    begin
      next_st.div = st.div + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      st <= '0;
      st.coarse <= trc_pkg::RST_RC_COARSE;
      st.fine <= trc_pkg::RST_RC_FINE;
      st.reg_en <= trc_pkg::RST_REG_EN;
      st.reg_lvl <= trc_pkg::RST_REG_LVL;
      st.coef_addr <= trc_pkg::RST_COEF_ADDR;
      st.tx_power <= trc_pkg::RST_TX_POWER;
      st.rate_hi <= trc_pkg::RST_RATE_HI;
      st.rate_lo <= trc_pkg::RST_RATE_LO;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rd_data_o = st.rd_data;
  assign rd_valid_o = st.rd_valid;
  assign coarse_cal_o = st.coarse_use;
  assign fine_cal_o = st.fine_use;
  assign ldo_en_o = st.ldo_en;
  assign smart_por_en_o = st.reg_en[trc_pkg::BIT_SPOR];
  assign dig_pwdn_en_o = st.reg_en[trc_pkg::BIT_DIGPWDN];
  assign xtal_ovr_o = st.reg_lvl[trc_pkg::BIT_XTAL];
  assign temp_sensor_en_o = st.reg_lvl[trc_pkg::BIT_TSENS];
  assign slow_osc_enable_o = st.reg_lvl[trc_pkg::BIT_SLOWOSC];
  assign dig_ldo_level_o = st.reg_lvl[2:0];
  assign antenna_switch_ctrl_o = st.ant_sw;
  assign tx_power_o = st.tx_power[2:0];
  assign tx_rate_o = {st.rate_hi, st.rate_lo};
  assign tx_bit_tick_o = st.tick;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_coarse_view;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (rd_en_i && addr_i == trc_pkg::OFS_RC_COARSE && !st.coarse[7])
      |=> rd_valid_o && rd_data_o[6:0] == $past(int_coarse_i) && !rd_data_o[7];
  endproperty
  a_coarse_view: assert property (p_coarse_view)
    else $error("coarse read did not show internal result");

  property p_coarse_use;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (!sys_rst_i && st.coarse[7]) |=> coarse_cal_o == $past(st.coarse[6:0]);
  endproperty
  a_coarse_use: assert property (p_coarse_use)
    else $error("coarse override value not used");

  property p_fine_view;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (rd_en_i && addr_i == trc_pkg::OFS_RC_FINE && !st.fine[7])
      |=> rd_data_o[6:0] == $past(int_fine_i);
  endproperty
  a_fine_view: assert property (p_fine_view)
    else $error("fine read did not show internal result");

  property p_fine_use;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (!sys_rst_i && !st.fine[7]) |=> fine_cal_o == $past(int_fine_i);
  endproperty
  a_fine_use: assert property (p_fine_use)
    else $error("fine value used without override");

  property p_reset_en;
    @(posedge core_clk_i) sys_rst_i
      |=> st.reg_en == trc_pkg::RST_REG_EN && st.tx_power == trc_pkg::RST_TX_POWER;
  endproperty
  a_reset_en: assert property (p_reset_en)
    else $error("wrong reset value");

  property p_ovr_on_only;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (!sys_rst_i && !st.reg_lvl[7])
      |=> ldo_en_o == ($past(st.reg_en[6:1]) | $past(sm_ldo_en_i));
  endproperty
  a_ovr_on_only: assert property (p_ovr_on_only)
    else $error("on-only override policy broken");

  property p_sw_off;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !st.tx_power[3] |=> !antenna_switch_ctrl_o;
  endproperty
  a_sw_off: assert property (p_sw_off)
    else $error("switch high while disabled");

  property p_sw_tx;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (!sys_rst_i && st.tx_power[3]) |=> antenna_switch_ctrl_o == $past(tx_mode_i);
  endproperty
  a_sw_tx: assert property (p_sw_tx)
    else $error("switch does not follow transmit mode");

  property p_reserved;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (rd_en_i && addr_i == trc_pkg::OFS_REG_LVL) |=> !rd_data_o[3];
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bit reads one");

  property p_tick_gap;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    tx_bit_tick_o |=> !tx_bit_tick_o [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("rate tick faster than step enable");

  c_override: cover property (@(posedge core_clk_i) st.coarse[7] && st.fine[7]);
  c_coef_rd: cover property (@(posedge core_clk_i)
    rd_valid_o && $past(addr_i) == trc_pkg::OFS_COEF_VAL);
  c_tick_scaled: cover property (@(posedge core_clk_i) tx_bit_tick_o && rate_scale_i);
  c_switch: cover property (@(posedge core_clk_i) antenna_switch_ctrl_o);

endmodule : trc_regs

/* verif/trc_host_model.sv */
// Host controller model driving the register port
`timescale 1ns/1ps

module trc_host_model (
  input wire logic core_clk_i,
  output logic wr_en_o,
  output logic rd_en_o,
  output logic [6:0] addr_o,
  output logic [7:0] wr_data_o
);
  initial
  begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = 7'h00;
    wr_data_o = 8'h00;
  end

  // --------------------------------------------------------------
  // Register port cycle
  // --------------------------------------------------------------
  // Host register write or read access, one cycle each
  task automatic acc(input logic wr, input logic [6:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    wr_en_o <= wr;
    rd_en_o <= !wr;
    addr_o <= a;
    wr_data_o <= d;
    @(posedge core_clk_i);
    wr_en_o <= 1'b0;
    rd_en_o <= 1'b0;
    addr_o <= ~a;
    wr_data_o <= ~d;
  endtask : acc
endmodule : trc_host_model

/* verif/tb_trc_regs.sv */
// Self-checking bench for the transmitter configuration registers
`timescale 1ns/1ps

module tb_trc_regs;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic wr_en, rd_en;
  logic [6:0] addr;
  logic [7:0] wr_data;
  logic [6:0] int_coarse_i = 7'h00;
  logic [6:0] int_fine_i = 7'h00;
  logic [5:0] sm_ldo_en_i = 6'h00;
  logic tx_mode_i = 1'b0;
  logic rate_scale_i = 1'b0;
  logic [7:0] rd_data_o;
  logic rd_valid_o;
  logic [6:0] coarse_cal_o, fine_cal_o;
  logic [5:0] ldo_en_o;
  logic smart_por_en_o, dig_pwdn_en_o, xtal_ovr_o, temp_sensor_en_o, slow_osc_enable_o;
  logic [2:0] dig_ldo_level_o, tx_power_o;
  logic antenna_switch_ctrl_o, tx_bit_tick_o;
  logic [15:0] tx_rate_o;
  logic [7:0] exp_q[$];
  int mismatches = 0;
  int checks_done = 0;

  always #50 core_clk_i = ~core_clk_i;

  trc_host_model trc_host_model_inst (.core_clk_i(core_clk_i), .wr_en_o(wr_en),
    .rd_en_o(rd_en), .addr_o(addr), .wr_data_o(wr_data));

  trc_regs trc_regs_inst (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .wr_en_i(wr_en),
    .rd_en_i(rd_en), .addr_i(addr), .wr_data_i(wr_data), .int_coarse_i(int_coarse_i),
    .int_fine_i(int_fine_i), .sm_ldo_en_i(sm_ldo_en_i), .tx_mode_i(tx_mode_i),
    .rate_scale_i(rate_scale_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .coarse_cal_o(coarse_cal_o), .fine_cal_o(fine_cal_o), .ldo_en_o(ldo_en_o),
    .smart_por_en_o(smart_por_en_o), .dig_pwdn_en_o(dig_pwdn_en_o), .xtal_ovr_o(xtal_ovr_o),
    .temp_sensor_en_o(temp_sensor_en_o), .slow_osc_enable_o(slow_osc_enable_o),
    .dig_ldo_level_o(dig_ldo_level_o), .antenna_switch_ctrl_o(antenna_switch_ctrl_o),
    .tx_power_o(tx_power_o), .tx_rate_o(tx_rate_o), .tx_bit_tick_o(tx_bit_tick_o));

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    trc_host_model_inst.acc(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    trc_host_model_inst.acc(1'b0, a, 8'h00);
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask : settle

  task automatic count_ticks(input int lo, input int hi);
    int n;
    n = 0;
    repeat (10000)
    begin
      @(negedge core_clk_i);
      if (tx_bit_tick_o === 1'b1)
        n++;
    end
    @(posedge core_clk_i);
    check(32'(n >= lo && n <= hi), 32'h1);
  endtask : count_ticks

  task automatic finish_test;
    $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  // --------------------------------------------------------------
  // Read monitor
  // --------------------------------------------------------------
  always @(negedge core_clk_i)
  begin
    if (rd_valid_o === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(32'(rd_data_o), 32'h100);
      else
        check(rd_data_o, exp_q.pop_front());
    end
  end

  initial
  begin
    #(60000 * 100);
    mismatches++;
    finish_test();
  end

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  initial
  begin
    logic [6:0] cr, fn;
    logic [5:0] p, sm, cv;
    void'($urandom(32'hB825));
    cr = 7'($urandom);
    fn = 7'($urandom);
    @(posedge core_clk_i);
    int_coarse_i <= cr;
    int_fine_i <= fn;
    repeat (11) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    settle(2);
    rd(trc_pkg::OFS_RC_COARSE, {1'b0, cr});
    rd(trc_pkg::OFS_RC_FINE, {1'b0, fn});
    rd(trc_pkg::OFS_REG_EN, 8'h81);
    rd(trc_pkg::OFS_REG_LVL, 8'h00);
    rd(trc_pkg::OFS_COEF_ADDR, 8'h00);
    rd(trc_pkg::OFS_TX_POWER, 8'h08);
    rd(trc_pkg::OFS_RATE_HI, 8'h0A);
    rd(trc_pkg::OFS_RATE_LO, trc_pkg::RST_RATE_LO);
    rd(7'h70, 8'h00);
    count_ticks(39, 41);
    for (int i = 0; i < 7; i++)
    begin
      wr(trc_pkg::OFS_COEF_ADDR, 8'(i));
      settle(2);
      rd(trc_pkg::OFS_COEF_VAL, {2'b00, trc_pkg::COEF_RST[i]});
      cv = 6'($urandom);
      wr(trc_pkg::OFS_COEF_VAL, {2'b11, cv});
      settle(2);
      rd(trc_pkg::OFS_COEF_VAL, {2'b00, cv});
    end
    wr(trc_pkg::OFS_COEF_ADDR, 8'hFF);
    settle(1);
    rd(trc_pkg::OFS_COEF_ADDR, 8'h07);
    wr(trc_pkg::OFS_RC_COARSE, {1'b1, ~cr});
    wr(trc_pkg::OFS_RC_FINE, {1'b1, ~fn});
    settle(3);
    check(coarse_cal_o, 7'(~cr));
    check(fine_cal_o, 7'(~fn));
    rd(trc_pkg::OFS_RC_FINE, {1'b1, ~fn});
    wr(trc_pkg::OFS_RC_COARSE, 8'h55);
    wr(trc_pkg::OFS_RC_FINE, 8'h2A);
    settle(3);
    check({coarse_cal_o, fine_cal_o}, {cr, fn});
    rd(trc_pkg::OFS_RC_COARSE, {1'b0, cr});
    p = 6'($urandom);
    sm = 6'($urandom);
    @(posedge core_clk_i);
    sm_ldo_en_i <= sm;
    wr(trc_pkg::OFS_REG_EN, {1'b1, p, 1'b1});
    wr(trc_pkg::OFS_REG_LVL, 8'hFF);
    settle(3);
    check(ldo_en_o, p);
    check({smart_por_en_o, dig_pwdn_en_o}, 2'h3);
    check({xtal_ovr_o, temp_sensor_en_o, slow_osc_enable_o, dig_ldo_level_o}, 6'h3F);
    rd(trc_pkg::OFS_REG_LVL, 8'hF7);
    wr(trc_pkg::OFS_REG_LVL, 8'h2A);
    settle(3);
    check(ldo_en_o, p | sm);
    check({xtal_ovr_o, temp_sensor_en_o, slow_osc_enable_o, dig_ldo_level_o}, 6'h12);
    @(posedge core_clk_i);
    tx_mode_i <= 1'b1;
    settle(3);
    check(antenna_switch_ctrl_o, 1'b1);
    @(posedge core_clk_i);
    tx_mode_i <= 1'b0;
    settle(3);
    check(antenna_switch_ctrl_o, 1'b0);
    wr(trc_pkg::OFS_TX_POWER, 8'hF5);
    @(posedge core_clk_i);
    tx_mode_i <= 1'b1;
    settle(3);
    check(antenna_switch_ctrl_o, 1'b0);
    check(tx_power_o, 3'h5);
    rd(trc_pkg::OFS_TX_POWER, 8'h05);
    wr(trc_pkg::OFS_RATE_HI, 8'h40);
    wr(trc_pkg::OFS_RATE_LO, 8'h00);
    settle(2);
    check(tx_rate_o, 16'h4000);
    count_ticks(249, 251);
    rate_scale_i <= 1'b1;
    count_ticks(7, 9);
    settle(3);
    check(exp_q.size(), 32'h0);
    finish_test();
  end
endmodule : tb_trc_regs
